// ===== rtl/page_region_check.sv
// Combinational region selection, length check and entry address.
// Assumes base and length inputs are held stable while in use.
`timescale 1ns/1ps
`default_nettype none

module page_region_check #(
  parameter int PA_W = 30
) (
  // Address to check
  input wire logic [31:0] vaddr,
  // Region table registers
  input wire logic [PA_W-1:0] sys_base,
  input wire logic [21:0] sys_len,
  input wire logic [31:0] prog_base,
  input wire logic [21:0] prog_len,
  input wire logic [31:0] ctl_base,
  input wire logic [21:0] ctl_len,
  // Result
  output logic in_range,
  output logic is_system,
  output logic [31:0] entry_addr
);

  // ****************************************************************
  // Entry address arithmetic
  // ****************************************************************
  function automatic logic [31:0] entry_address(input logic [31:0] base,
                                                input logic [21:0] index);
    entry_address = base + {8'h00, index, 2'h0};
  endfunction

  logic [1:0] region;
  logic [20:0] vpn_low;
  logic [21:0] vpn_full;
  logic [22:0] ctl_sum;

  always_comb
  begin
    region = vaddr[31:30];
    vpn_low = vaddr[29:page_xlate_pkg::PAGE_BITS];
    vpn_full = vaddr[30:page_xlate_pkg::PAGE_BITS];
    ctl_sum = {1'b0, vpn_full} + {1'b0, ctl_len};
    in_range = 1'b0;
    is_system = 1'b0;
    entry_addr = 32'h00000000;
    unique case (region)
      page_xlate_pkg::REGION_PROGRAM:
      begin
        in_range = {1'b0, vpn_low} < prog_len;
        entry_addr = entry_address(prog_base, {1'b0, vpn_low});
      end
      page_xlate_pkg::REGION_CONTROL:
      begin
        // Pages from the top minus the length up to the last page are valid.
        in_range = ctl_sum >= page_xlate_pkg::CTL_TOP;
        entry_addr = entry_address(ctl_base, ctl_sum[21:0]);
      end
      page_xlate_pkg::REGION_SYSTEM:
      begin
        in_range = {1'b0, vpn_low} < sys_len;
        is_system = 1'b1;
        entry_addr = entry_address({{(32-PA_W){1'b0}}, sys_base}, {1'b0, vpn_low});
      end
      default:
      begin
        in_range = 1'b0;
      end
    endcase
  end

endmodule // page_region_check

`default_nettype wire

// ===== rtl/page_xlate_pkg.sv
// Constants shared by the page translation unit and its region checker.
// Assumes 32-bit virtual addresses and longword page map entries.
package page_xlate_pkg;

  // ****************************************************************
  // Address layout
  // ****************************************************************
  localparam int VA_W = 32;
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_BITS = 9;
  localparam int ENTRY_BYTES = 4;
  localparam int ENTRY_SHIFT = 2;
  localparam int ENTRIES_PER_PAGE = PAGE_BYTES / ENTRY_BYTES;
  localparam int LEN_W = 22;
  localparam logic [LEN_W:0] CTL_TOP = 23'h400000;

  // ****************************************************************
  // Region codes from the two top virtual address bits
  // ****************************************************************
  localparam logic [1:0] REGION_PROGRAM = 2'h0;
  localparam logic [1:0] REGION_CONTROL = 2'h1;
  localparam logic [1:0] REGION_SYSTEM = 2'h2;

  // ****************************************************************
  // Page map entry fields
  // ****************************************************************
  localparam int ENTRY_VALID_BIT = 31;
  localparam int ENTRY_MOD_BIT = 26;
  localparam logic [31:0] ENTRY_MOD_MASK = 32'h04000000;

endpackage : page_xlate_pkg

// ===== rtl/virtual_page_translation.sv
// Virtual to physical page translation with page map entry fetch.
// Assumes one memory port that answers each request with mem_ack, read data valid with it.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - A write access sets the modified bit in the page's map entry.
// - Only the modified bit is ever changed in an entry written back.
// - Page number is checked against region length before any entry fetch.
// - System table base is physical; system entries are fetched directly.
// - Per-process entry addresses are translated through the system table first.
// - Program table indexes upward from page zero below the length.
// - Control table covers top pages down to top minus length.
// - System table starts at page zero, last entry at length minus one.
// - One page holds 128 entries, so one system entry maps one table page.
// - Pages are 512 bytes; byte offset passes straight to the physical address.
// - The two top virtual address bits select the region.
// - Entries are longwords indexed by page number from the region base; control counts pages from top minus length.
// - Three base and length pairs, one per region.
module virtual_page_translation #(
  parameter int PA_W = 30
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Region registers
  input wire logic [PA_W-1:0] sys_base,
  input wire logic [21:0] sys_len,
  input wire logic [31:0] prog_base,
  input wire logic [21:0] prog_len,
  input wire logic [31:0] ctl_base,
  input wire logic [21:0] ctl_len,
  // Translation request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [31:0] req_vaddr,
  input wire logic req_write,
  // Translation answer
  output logic resp_valid,
  output logic [PA_W-1:0] resp_paddr,
  output logic resp_len_fault,
  output logic resp_inv_fault,
  // Table memory
  output logic mem_req,
  output logic mem_write,
  output logic [PA_W-1:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);

  localparam int FRAME_W = PA_W - page_xlate_pkg::PAGE_BITS;

  typedef enum logic [2:0] {IDLE, CHECK, SYS_RD, ENTRY_RD, MOD_WR, DONE} state_t;

  // ****************************************************************
  // Registers
  // ****************************************************************
  state_t state, next_state;
  logic [31:0] vaddr, next_vaddr;
  logic write, next_write;
  logic [31:0] table_vaddr, next_table_vaddr;
  logic [PA_W-1:0] addr, next_addr;
  logic [31:0] wdata, next_wdata;
  logic [PA_W-1:0] paddr, next_paddr;
  logic len_fault, next_len_fault;
  logic inv_fault, next_inv_fault;

  // ****************************************************************
  // Region checks: the access itself, then its table entry address
  // ****************************************************************
  logic a_ok, a_sys, b_ok, b_sys;
  logic [31:0] a_entry, b_entry;

  page_region_check #(.PA_W(PA_W)) check_access (
    .vaddr(vaddr),
    .sys_base(sys_base),
    .sys_len(sys_len),
    .prog_base(prog_base),
    .prog_len(prog_len),
    .ctl_base(ctl_base),
    .ctl_len(ctl_len),
    .in_range(a_ok),
    .is_system(a_sys),
    .entry_addr(a_entry)
  );

  // The per-process entry address is itself a system-region address.
  page_region_check #(.PA_W(PA_W)) check_table (
    .vaddr(a_entry),
    .sys_base(sys_base),
    .sys_len(sys_len),
    .prog_base(prog_base),
    .prog_len(prog_len),
    .ctl_base(ctl_base),
    .ctl_len(ctl_len),
    .in_range(b_ok),
    .is_system(b_sys),
    .entry_addr(b_entry)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    next_vaddr = vaddr;
    next_write = write;
    next_table_vaddr = table_vaddr;
    next_addr = addr;
    next_wdata = wdata;
    next_paddr = paddr;
    next_len_fault = len_fault;
    next_inv_fault = inv_fault;
    unique case (state)
      IDLE:
      begin
        if (req_valid)
        begin
          next_vaddr = req_vaddr;
          next_write = req_write;
          next_len_fault = 1'b0;
          next_inv_fault = 1'b0;
          next_state = CHECK;
        end
      end
      CHECK:
      begin
        if (!a_ok)
        begin
          next_len_fault = 1'b1;
          next_state = DONE;
        end
        else if (a_sys)
        begin
          next_addr = a_entry[PA_W-1:0];
          next_state = ENTRY_RD;
        end
        else if (!(b_ok && b_sys))
        begin
          // A table address outside the system table is a length fault too.
          next_len_fault = 1'b1;
          next_state = DONE;
        end
        else
        begin
          next_table_vaddr = a_entry;
          next_addr = b_entry[PA_W-1:0];
          next_state = SYS_RD;
        end
      end
      SYS_RD:
      begin
        if (mem_ack)
        begin
          if (!mem_rdata[page_xlate_pkg::ENTRY_VALID_BIT])
          begin
            next_inv_fault = 1'b1;
            next_state = DONE;
          end
          else
          begin
            // One system entry maps a whole page of process entries.
            next_addr = {mem_rdata[FRAME_W-1:0],
                         table_vaddr[page_xlate_pkg::PAGE_BITS-1:0]};
            next_state = ENTRY_RD;
          end
        end
      end
      ENTRY_RD:
      begin
        if (mem_ack)
        begin
          next_paddr = {mem_rdata[FRAME_W-1:0],
                        vaddr[page_xlate_pkg::PAGE_BITS-1:0]};
          if (!mem_rdata[page_xlate_pkg::ENTRY_VALID_BIT])
          begin
            next_inv_fault = 1'b1;
            next_state = DONE;
          end
          else if (write && !mem_rdata[page_xlate_pkg::ENTRY_MOD_BIT])
          begin
            next_wdata = mem_rdata | page_xlate_pkg::ENTRY_MOD_MASK;
            next_state = MOD_WR;
          end
          else
          begin
            next_state = DONE;
          end
        end
      end
      MOD_WR:
      begin
        if (mem_ack)
        begin
          next_state = DONE;
        end
      end
      DONE:
      begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= IDLE;
      vaddr <= 32'h00000000;
      write <= 1'b0;
      table_vaddr <= 32'h00000000;
      addr <= '0;
      wdata <= 32'h00000000;
      paddr <= '0;
      len_fault <= 1'b0;
      inv_fault <= 1'b0;
    end
    else
    begin
      state <= next_state;
      vaddr <= next_vaddr;
      write <= next_write;
      table_vaddr <= next_table_vaddr;
      addr <= next_addr;
      wdata <= next_wdata;
      paddr <= next_paddr;
      len_fault <= next_len_fault;
      inv_fault <= next_inv_fault;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign req_ready = (state == IDLE);
  assign resp_valid = (state == DONE);
  assign resp_paddr = paddr;
  assign resp_len_fault = len_fault;
  assign resp_inv_fault = inv_fault;
  assign mem_req = (state == SYS_RD) || (state == ENTRY_RD) || (state == MOD_WR);
  assign mem_write = (state == MOD_WR);
  assign mem_addr = addr;
  assign mem_wdata = wdata;

  // ****************************************************************
  // Checks
  // ****************************************************************
  mod_only_a: assert property (@(posedge mclk) disable iff (!nrst)
    mem_req && mem_write |->
      (mem_wdata & ~page_xlate_pkg::ENTRY_MOD_MASK) ==
      ($past(mem_rdata, 1) & ~page_xlate_pkg::ENTRY_MOD_MASK) || $past(mem_write, 1))
    else $error("Entry write-back changed more than the modified bit.");

  mod_set_a: assert property (@(posedge mclk) disable iff (!nrst)
    mem_req && mem_write |-> mem_wdata[page_xlate_pkg::ENTRY_MOD_BIT])
    else $error("Entry write-back without the modified bit set.");

  fault_no_mem_a: assert property (@(posedge mclk) disable iff (!nrst)
    state == CHECK && !a_ok |=> !mem_req && resp_valid && resp_len_fault)
    else $error("Length fault did not abort without memory access.");

  prog_range_a: assert property (@(posedge mclk) disable iff (!nrst)
    state == CHECK && vaddr[31:30] == page_xlate_pkg::REGION_PROGRAM |->
      a_ok == ({1'b0, vaddr[29:9]} < prog_len))
    else $error("Program region length check wrong.");

  ctl_range_a: assert property (@(posedge mclk) disable iff (!nrst)
    state == CHECK && vaddr[31:30] == page_xlate_pkg::REGION_CONTROL &&
      vaddr[30:9] == 22'h3FFFFF && ctl_len != 22'h000000 |-> a_ok)
    else $error("Top control page rejected with nonzero length.");

  sys_direct_a: assert property (@(posedge mclk) disable iff (!nrst)
    state == CHECK && a_ok && a_sys |=> state == ENTRY_RD &&
      mem_addr == sys_base + {vaddr[29:9], 2'h0})
    else $error("System entry not fetched from physical base.");

  proc_via_sys_a: assert property (@(posedge mclk) disable iff (!nrst)
    state == CHECK && a_ok && !a_sys |=> state == SYS_RD || (state == DONE && len_fault))
    else $error("Process entry fetched without system translation.");

  offset_pass_a: assert property (@(posedge mclk) disable iff (!nrst)
    resp_valid && !resp_len_fault && !resp_inv_fault |->
      resp_paddr[8:0] == vaddr[8:0])
    else $error("Byte offset changed by translation.");

  answer_bound_a: assert property (@(posedge mclk) disable iff (!nrst)
    state == CHECK && !a_ok |-> ##[1:2] resp_valid)
    else $error("Length fault not answered in time.");

endmodule // virtual_page_translation

`default_nettype wire

// ===== sim/table_mem_model.sv
// Behavioural memory holding the page tables behind the translation unit.
// Assumes every table address lies in the lowest 4 KB; the bench loads store directly.
`timescale 1ns/1ps
`default_nettype none

module table_mem_model #(
  parameter int PA_W = 30
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Answer pacing
  input wire logic [3:0] ack_delay,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [PA_W-1:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // ****************************************************************
  // Storage and pacing
  // ****************************************************************
  logic [31:0] store [0:1023];
  logic [31:0] last;
  logic [3:0] cnt;
  int n_ack;

  // Outside an ack the data lines show the inverse of the last word, so stale reads fail.
  assign mem_ack = mem_req && (cnt >= ack_delay);
  assign mem_rdata = mem_ack ? store[mem_addr[11:2]] : ~last;

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 4'h0;
      last <= 32'h0;
      n_ack <= 0;
    end
    else if (mem_ack)
    begin
      cnt <= 4'h0;
      n_ack <= n_ack + 1;
      last <= mem_rdata;
      if (mem_write)
        store[mem_addr[11:2]] <= mem_wdata;
    end
    else if (mem_req)
      cnt <= cnt + 4'h1;
  end
endmodule // table_mem_model
`default_nettype wire

// ===== sim/virtual_page_translation_test.sv
// Self-checking bench for the page translation unit against a table memory model.
// Assumes the model answers after ack_delay cycles and tables sit below 4 KB.
`timescale 1ns/1ps
`default_nettype none

module virtual_page_translation_test;
  // ****************************************************************
  // Signals and cases
  // ****************************************************************
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid, req_ready, req_write, resp_valid, resp_len_fault, resp_inv_fault;
  logic [31:0] req_vaddr, mem_wdata, mem_rdata;
  logic [29:0] resp_paddr, mem_addr;
  logic mem_req, mem_write, mem_ack;
  logic [3:0] ack_delay = 4'h0;
  logic [21:0] prog_len = 22'h4;
  int num_errors = 0;
  int n_compared = 0;
  int base;
  typedef struct {logic [31:0] va; logic wr; logic [1:0] flt; logic [29:0] pa; int acc;} row_t;
  row_t rows [17] = '{
    '{32'h80000A10, 1'b0, 2'h0, 30'h0AA10, 1},
    '{32'h80001FFC, 1'b0, 2'h0, 30'h0FFFC, 1},
    '{32'h80002000, 1'b0, 2'h2, 30'h0, 0},
    '{32'hC0000000, 1'b0, 2'h2, 30'h0, 0},
    '{32'h80000C00, 1'b0, 2'h1, 30'h0, 1},
    '{32'h00000004, 1'b0, 2'h0, 30'h22204, 2},
    '{32'h000007FF, 1'b0, 2'h0, 30'h889FF, 2},
    '{32'h00000800, 1'b0, 2'h2, 30'h0, 0},
    '{32'h00000400, 1'b0, 2'h1, 30'h0, 2},
    '{32'h7FFFFA08, 1'b0, 2'h0, 30'h66608, 2},
    '{32'h7FFFFFFF, 1'b0, 2'h0, 30'h757FF, 2},
    '{32'h7FFFF800, 1'b0, 2'h2, 30'h0, 0},
    '{32'h00000200, 1'b1, 2'h0, 30'h44400, 2},
    '{32'h00000010, 1'b1, 2'h0, 30'h22210, 3},
    '{32'h00000010, 1'b1, 2'h0, 30'h22210, 2},
    '{32'h80000A00, 1'b1, 2'h0, 30'h0AA00, 2},
    '{32'h00000400, 1'b1, 2'h1, 30'h0, 2}
  };

  always #12.5 mclk = ~mclk;

  virtual_page_translation i_dut (.mclk(mclk), .nrst(nrst), .sys_base(30'h100),
    .sys_len(22'h10), .prog_base(32'h80000000), .prog_len(prog_len), .ctl_base(32'h80000200),
    .ctl_len(22'h3), .req_valid(req_valid), .req_ready(req_ready), .req_vaddr(req_vaddr),
    .req_write(req_write), .resp_valid(resp_valid), .resp_paddr(resp_paddr),
    .resp_len_fault(resp_len_fault), .resp_inv_fault(resp_inv_fault), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  table_mem_model i_mem (.mclk(mclk), .nrst(nrst), .ack_delay(ack_delay), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xlate(input logic [31:0] va, input logic wr);
    int n;
    n = 0;
    @(posedge mclk);
    #2;
    req_valid = 1'b1;
    req_vaddr = va;
    req_write = wr;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      #2;
      n++;
    end
    @(posedge mclk);
    #2;
    req_valid = 1'b0;
    while (resp_valid !== 1'b1 && n < 100)
    begin
      @(posedge mclk);
      #2;
      n++;
    end
    check("answer in time", 32'h1, 32'(n < 100));
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    req_valid = 1'b0;
    req_vaddr = 32'h0;
    req_write = 1'b0;
    for (int k = 0; k < 1024; k++)
      i_mem.store[k] = 32'h0;
    // The system table is one contiguous physical run from 0x100.
    i_mem.store[64] = 32'h80000002;
    i_mem.store[65] = 32'h80000003;
    i_mem.store[69] = 32'h80000055;
    i_mem.store[70] = 32'h00000055;
    i_mem.store[79] = 32'h8000007F;
    i_mem.store[256] = 32'h80000111;
    i_mem.store[257] = 32'h84000222;
    i_mem.store[258] = 32'h00000999;
    i_mem.store[259] = 32'h80000444;
    i_mem.store[384] = 32'h80000333;
    i_mem.store[386] = 32'h800003AB;
    repeat (4) @(posedge mclk);
    #2;
    check("reset outputs", 32'h4, {29'h0, req_ready, resp_valid, mem_req});
    repeat (4) @(posedge mclk);
    #2;
    nrst = 1'b1;
    foreach (rows[i])
    begin
      ack_delay = 4'(i % 3);
      base = i_mem.n_ack;
      xlate(rows[i].va, rows[i].wr);
      check("faults", {30'h0, rows[i].flt}, {30'h0, resp_len_fault, resp_inv_fault});
      if (rows[i].flt == 2'h0)
        check("paddr", {2'h0, rows[i].pa}, {2'h0, resp_paddr});
      check("accesses", 32'(rows[i].acc), 32'(i_mem.n_ack - base));
    end
    check("entry p0", 32'h84000111, i_mem.store[256]);
    check("entry p1", 32'h84000222, i_mem.store[257]);
    check("entry p2", 32'h00000999, i_mem.store[258]);
    check("entry s5", 32'h84000055, i_mem.store[69]);
    // A longer program table admits page 4, whose entry is not valid.
    prog_len = 22'h5;
    xlate(32'h00000800, 1'b0);
    check("grown table", 32'h1, {30'h0, resp_len_fault, resp_inv_fault});
    // A table address past the system table length must be refused before any fetch.
    prog_len = 22'h801;
    base = i_mem.n_ack;
    xlate(32'h00100000, 1'b0);
    check("table beyond system", 32'h2, {30'h0, resp_len_fault, resp_inv_fault});
    check("table beyond accesses", 32'h0, 32'(i_mem.n_ack - base));
    prog_len = 22'h4;
    // A reset in mid-walk must drop the memory request at once.
    ack_delay = 4'h9;
    @(posedge mclk);
    #2;
    req_valid = 1'b1;
    req_vaddr = 32'h00000010;
    @(posedge mclk);
    #2;
    req_valid = 1'b0;
    repeat (3) @(posedge mclk);
    #2;
    nrst = 1'b0;
    #1;
    check("mid reset", 32'h4, {29'h0, req_ready, resp_valid, mem_req});
    @(posedge mclk);
    #2;
    nrst = 1'b1;
    ack_delay = 4'h0;
    xlate(32'h80000A10, 1'b0);
    check("paddr after reset", 32'h0000AA10, {2'h0, resp_paddr});
    finish_test();
  end

  initial
  begin
    #75000;
    num_errors++;
    finish_test();
  end
endmodule // virtual_page_translation_test
`default_nettype wire
